// File: logic/vic_unit.sv
// vectored interrupt unit: command registers, vector read, level stack
// assumes a core end on vic_link_if.dev and source pins from outside
// What this block does
// - clear command ones clear matching sources
// - set command ones force matching sources
// - any end-of-interrupt write ends treatment
// - spurious handler vector, read/write, resets zero
// - vector read makes highest pending current
// - vector read drops line; software must read
// - vector read clears edge-triggered current source
// - vector read pushes current level on stack
// - vector read returns current source's handler
// - end write pops stack, restores prior level
// - after pop, reassert line if higher pending
// - higher than current level reasserts line
// - software removes level-sensitive cause itself
// - handler masks core, then writes end
// - core accepts line only while unmasked
// - saved link register reduced by four
// - no current interrupt reads vector zero
// - current source number readable
module vic_unit (
  input wire logic i_core_clk,
  input wire logic i_reset,
  vic_link_if.dev lnk,
  input wire logic [vic_pkg::NUM_SRC-1:0] i_src,
  input wire logic [vic_pkg::NUM_SRC-1:0] i_src_edge,
  input wire logic [vic_pkg::NUM_SRC-1:0] i_src_enable,
  input wire logic [vic_pkg::NUM_SRC*vic_pkg::PRIO_W-1:0] i_src_prio,
  input wire logic i_vec_we,
  input wire logic [vic_pkg::SRC_W-1:0] i_vec_idx,
  input wire logic [vic_pkg::DATA_W-1:0] i_vec_data,
  output logic [vic_pkg::NUM_SRC-1:0] o_pending,
  output logic [vic_pkg::SRC_W-1:0] o_cur_src,
  output logic [vic_pkg::PRIO_W-1:0] o_cur_level,
  output logic [vic_pkg::SP_W-1:0] o_nest_depth
);

  // ************************************************************
  // ***** register decode
  // ************************************************************
  wire wr_clear = lnk.wr_en && lnk.addr == vic_pkg::OFS_INT_CLEAR_CMD;
  wire wr_set = lnk.wr_en && lnk.addr == vic_pkg::OFS_INT_SET_CMD;
  wire wr_eoi = lnk.wr_en && lnk.addr == vic_pkg::OFS_END_OF_INT_CMD;
  wire wr_spu = lnk.wr_en && lnk.addr == vic_pkg::OFS_SPURIOUS_VECTOR;
  wire rd_ivr = lnk.rd_en && lnk.addr == vic_pkg::OFS_CUR_VECTOR;
  wire rd_isr = lnk.rd_en && lnk.addr == vic_pkg::OFS_CUR_SOURCE_ID;
  wire rd_spu = lnk.rd_en && lnk.addr == vic_pkg::OFS_SPURIOUS_VECTOR;

  // write data restricted to real sources
  wire [vic_pkg::NUM_SRC-1:0] clr_cmd =
    wr_clear ? (lnk.wdata & vic_pkg::SRC_IMPL_MASK) : '0;
  wire [vic_pkg::NUM_SRC-1:0] set_cmd =
    wr_set ? (lnk.wdata & vic_pkg::SRC_IMPL_MASK) : '0;

  // ************************************************************
  // ***** state
  // ************************************************************
  logic [vic_pkg::NUM_SRC-1:0] src_s1;
  logic [vic_pkg::NUM_SRC-1:0] src_s2;
  logic [vic_pkg::NUM_SRC-1:0] src_prev;
  logic [vic_pkg::NUM_SRC-1:0] pend_q;
  logic [vic_pkg::DATA_W-1:0] spu_vec;
  logic [vic_pkg::DATA_W-1:0] vec_mem [vic_pkg::NUM_SRC];
  logic [vic_pkg::SRC_W-1:0] stk_src [vic_pkg::STACK_DEPTH];
  logic [vic_pkg::PRIO_W-1:0] stk_lvl [vic_pkg::STACK_DEPTH];
  logic [vic_pkg::SP_W-1:0] sp;
  logic irq_q;
  logic [vic_pkg::DATA_W-1:0] rdata_q;
  logic rvalid_q;

  // ************************************************************
  // ***** pending per source
  // ************************************************************
  logic [vic_pkg::NUM_SRC-1:0] cand;
  logic [vic_pkg::NUM_SRC-1:0] ack_clr;
  logic [vic_pkg::NUM_SRC-1:0] next_pend;
  logic [vic_pkg::NUM_SRC-1:0] pending;
  logic [vic_pkg::PRIO_W-1:0] prio [vic_pkg::NUM_SRC];
  logic [vic_pkg::SRC_W-1:0] best_idx;
  logic take;

  genvar g;
  generate
    for (g = 0; g < vic_pkg::NUM_SRC; g++) begin : g_src
      wire rise = i_src_edge[g] && src_s2[g] && !src_prev[g];
      wire impl = vic_pkg::SRC_IMPL_MASK[g];
      assign prio[g] =
        i_src_prio[g*vic_pkg::PRIO_W +: vic_pkg::PRIO_W];
      // edge source cleared once it becomes current
      assign ack_clr[g] = take && best_idx == vic_pkg::SRC_W'(g) &&
        i_src_edge[g];
      // a new event beats a clear in the same cycle
      assign next_pend[g] = impl && (set_cmd[g] || (rise && impl) ||
        (pend_q[g] && !clr_cmd[g] && !ack_clr[g]));
      // a level source stays pending while its pin is held
      assign pending[g] = impl &&
        (pend_q[g] || (!i_src_edge[g] && src_s2[g]));
      assign cand[g] = pending[g] && i_src_enable[g] &&
        g != vic_pkg::FAST_SRC_IDX;
    end
  endgenerate

  // ************************************************************
  // ***** priority search and level stack
  // ************************************************************
  logic [vic_pkg::PRIO_W-1:0] best_prio;
  logic best_valid;

  // highest priority wins; on a tie the lower number wins
  always_comb begin
    best_idx = '0;
    best_prio = '0;
    best_valid = 1'b0;
    for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (cand[i] && (!best_valid || prio[i] >= best_prio)) begin
        best_idx = vic_pkg::SRC_W'(i);
        best_prio = prio[i];
        best_valid = 1'b1;
      end
    end
  end

  wire [2:0] top_idx = 3'(sp - 4'h1);
  wire has_cur = sp != '0;
  wire [vic_pkg::PRIO_W-1:0] cur_lvl = has_cur ? stk_lvl[top_idx] : '0;
  wire [vic_pkg::SRC_W-1:0] cur_src = has_cur ? stk_src[top_idx] : '0;
  // an empty stack means no level: any enabled pending source except source 0 qualifies
  wire qualify = best_valid &&
    (!has_cur || best_prio > cur_lvl);
  wire stack_full = sp == vic_pkg::SP_W'(vic_pkg::STACK_DEPTH);
  // a full stack refuses the nest: reads then return the current source's vector
  assign take = rd_ivr && qualify && !stack_full;
  wire pop = wr_eoi && has_cur;

  // ************************************************************
  // ***** read data
  // ************************************************************
  logic [vic_pkg::DATA_W-1:0] ivr_data;
  logic [vic_pkg::DATA_W-1:0] next_rdata;

  always_comb begin
    if (take) begin
      ivr_data = vec_mem[best_idx];
    end else if (irq_q) begin
      // the line was up but its cause went away
      ivr_data = spu_vec;
    end else if (has_cur) begin
      ivr_data = vec_mem[cur_src];
    end else begin
      ivr_data = vic_pkg::NO_CURRENT_VECTOR;
    end
  end

  always_comb begin
    next_rdata = '0;
    if (rd_ivr) begin
      next_rdata = ivr_data;
    end else if (rd_isr) begin
      next_rdata = vic_pkg::DATA_W'(cur_src);
    end else if (rd_spu) begin
      next_rdata = spu_vec;
    end
  end

  // ************************************************************
  // ***** clocked state
  // ************************************************************
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      src_s1 <= '0;
      src_s2 <= '0;
      src_prev <= '0;
      pend_q <= '0;
    end else begin
      src_s1 <= i_src;
      src_s2 <= src_s1;
      src_prev <= src_s2;
      pend_q <= next_pend;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      spu_vec <= vic_pkg::SPURIOUS_RESET;
    end else if (wr_spu) begin
      spu_vec <= lnk.wdata;
    end
  end

  // vectors come from the neighbouring source vector registers
  always_ff @(posedge i_core_clk) begin
    if (i_vec_we) begin
      vec_mem[i_vec_idx] <= i_vec_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sp <= '0;
    end else if (take) begin
      sp <= sp + 4'h1;
    end else if (pop) begin
      sp <= sp - 4'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (take) begin
      stk_src[3'(sp)] <= best_idx;
      stk_lvl[3'(sp)] <= best_prio;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_q <= 1'b0;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      irq_q <= qualify && !rd_ivr && !stack_full;
      rdata_q <= next_rdata;
      rvalid_q <= lnk.rd_en;
    end
  end

  // ************************************************************
  // ***** outputs
  // ************************************************************
  assign lnk.normal_interrupt_line_n = !irq_q;
  assign lnk.rdata = rdata_q;
  assign lnk.rvalid = rvalid_q;
  assign o_pending = pend_q;
  assign o_cur_src = cur_src;
  assign o_cur_level = cur_lvl;
  assign o_nest_depth = sp;

endmodule : vic_unit

// File: common/vic_pkg.sv
// constants shared by both ends of the interrupt command and nesting link
// assumes one core clock and one reset for both ends
package vic_pkg;

  // ************************************************************
  // ***** sizes
  // ************************************************************
  localparam int NUM_SRC = 32;
  localparam int SRC_W = 5;
  localparam int PRIO_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 4;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ************************************************************
  // ***** register offsets (byte addresses)
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_CUR_VECTOR = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_CUR_SOURCE_ID = 12'h108;
  localparam logic [ADDR_W-1:0] OFS_INT_CLEAR_CMD = 12'h128;
  localparam logic [ADDR_W-1:0] OFS_INT_SET_CMD = 12'h12C;
  localparam logic [ADDR_W-1:0] OFS_END_OF_INT_CMD = 12'h130;
  localparam logic [ADDR_W-1:0] OFS_SPURIOUS_VECTOR = 12'h134;

  // ************************************************************
  // ***** fields and reset values
  // ************************************************************
  // positions 21 and 22 hold no source
  localparam logic [NUM_SRC-1:0] SRC_IMPL_MASK = 32'hFF9F_FFFF;
  localparam int FAST_SRC_IDX = 0;
  localparam logic [DATA_W-1:0] SPURIOUS_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] NO_CURRENT_VECTOR = 32'h0000_0000;

  // ************************************************************
  // ***** core side
  // ************************************************************
  localparam logic [DATA_W-1:0] CORE_IRQ_ENTRY_ADDR = 32'h0000_0018;
  localparam logic [DATA_W-1:0] LINK_ADJUST = 32'h0000_0004;

endpackage : vic_pkg

// File: common/vic_link_if.sv
// register link between the core end and the vectored interrupt unit
// assumes both ends run on the same core clock
interface vic_link_if;
  logic [vic_pkg::ADDR_W-1:0] addr;
  logic wr_en;
  logic rd_en;
  logic [vic_pkg::DATA_W-1:0] wdata;
  logic [vic_pkg::DATA_W-1:0] rdata;
  logic rvalid;
  logic normal_interrupt_line_n;

  modport dev (
    input addr, wr_en, rd_en, wdata,
    output rdata, rvalid, normal_interrupt_line_n
  );

  modport core (
    output addr, wr_en, rd_en, wdata,
    input rdata, rvalid, normal_interrupt_line_n
  );
endinterface : vic_link_if

// File: logic/vic_core_end.sv
// core end: entry and exit sequence plus plain register commands
// assumes the unit on vic_link_if.core and one shared core clock
module vic_core_end (
  input wire logic i_core_clk,
  input wire logic i_reset,
  vic_link_if.core lnk,
  input wire logic i_irq_disable,
  input wire logic [vic_pkg::DATA_W-1:0] i_core_status,
  input wire logic [vic_pkg::DATA_W-1:0] i_return_pc,
  input wire logic i_exit,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic [vic_pkg::ADDR_W-1:0] i_cmd_addr,
  input wire logic [vic_pkg::DATA_W-1:0] i_cmd_wdata,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [vic_pkg::DATA_W-1:0] o_rsp_data,
  output logic o_irq_entry,
  output logic o_exit_done,
  output logic [vic_pkg::DATA_W-1:0] o_handler_addr,
  output logic [vic_pkg::DATA_W-1:0] o_saved_status,
  output logic [vic_pkg::DATA_W-1:0] o_saved_link,
  output logic [vic_pkg::DATA_W-1:0] o_fetch_addr,
  output logic [vic_pkg::SP_W-1:0] o_nest_count
);

  // ************************************************************
  // ***** sequencer
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_VEC_WAIT = 3'b010,
    ST_CMD_WAIT = 3'b100
  } vic_core_state_t;

  vic_core_state_t state;
  vic_core_state_t next_state;

  wire idle = state == ST_IDLE;
  // line is sampled only while the core is unmasked
  wire accept = idle && !lnk.normal_interrupt_line_n &&
    !i_irq_disable;
  // leaving is honoured only once the core has masked itself
  wire do_exit = idle && !accept && i_exit && i_irq_disable;
  wire do_cmd = idle && !accept && !do_exit && i_cmd_valid;
  assign o_cmd_ready = idle && !accept && !do_exit;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_VEC_WAIT;
        end else if (do_cmd && !i_cmd_write) begin
          next_state = ST_CMD_WAIT;
        end
      end
      ST_VEC_WAIT: begin
        if (lnk.rvalid) begin
          next_state = ST_IDLE;
        end
      end
      ST_CMD_WAIT: begin
        if (lnk.rvalid) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // ************************************************************
  // ***** link drive
  // ************************************************************
  logic bus_wr;
  logic bus_rd;
  logic [vic_pkg::ADDR_W-1:0] bus_addr;
  logic [vic_pkg::DATA_W-1:0] bus_wdata;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= ST_IDLE;
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
      bus_addr <= '0;
      bus_wdata <= '0;
    end else begin
      state <= next_state;
      // the vector read is issued even if the vector goes unused
      bus_rd <= accept || (do_cmd && !i_cmd_write);
      bus_wr <= do_exit || (do_cmd && i_cmd_write);
      if (accept) begin
        bus_addr <= vic_pkg::OFS_CUR_VECTOR;
      end else if (do_exit) begin
        bus_addr <= vic_pkg::OFS_END_OF_INT_CMD;
        bus_wdata <= '0;
      end else if (do_cmd) begin
        bus_addr <= i_cmd_addr;
        bus_wdata <= i_cmd_wdata;
      end
    end
  end

  assign lnk.rd_en = bus_rd;
  assign lnk.wr_en = bus_wr;
  assign lnk.addr = bus_addr;
  assign lnk.wdata = bus_wdata;

  // ************************************************************
  // ***** entry bookkeeping
  // ************************************************************
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_irq_entry <= 1'b0;
      o_exit_done <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data <= '0;
      o_handler_addr <= '0;
      o_saved_status <= '0;
      o_saved_link <= '0;
      o_fetch_addr <= '0;
      o_nest_count <= '0;
    end else begin
      o_irq_entry <= accept;
      o_exit_done <= do_exit;
      o_rsp_valid <= state == ST_CMD_WAIT && lnk.rvalid;
      if (state == ST_CMD_WAIT && lnk.rvalid) begin
        o_rsp_data <= lnk.rdata;
      end
      if (accept) begin
        o_saved_status <= i_core_status;
        o_saved_link <= i_return_pc - vic_pkg::LINK_ADJUST;
        o_fetch_addr <= vic_pkg::CORE_IRQ_ENTRY_ADDR;
        o_nest_count <= o_nest_count + 4'h1;
      end else if (do_exit && o_nest_count != '0) begin
        o_nest_count <= o_nest_count - 4'h1;
      end
      if (state == ST_VEC_WAIT && lnk.rvalid) begin
        o_handler_addr <= lnk.rdata;
      end
    end
  end

endmodule : vic_core_end

// File: sim/vic_link_asserts.sv
// checker for the register link between core end and interrupt unit
// assumes it sits beside the link interface on the one core clock
module vic_link_asserts (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [vic_pkg::ADDR_W-1:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [vic_pkg::DATA_W-1:0] wdata,
  input wire logic [vic_pkg::DATA_W-1:0] rdata,
  input wire logic rvalid,
  input wire logic normal_interrupt_line_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // ***** shadow of stack depth and spurious vector
  // ************************************************************
  logic [vic_pkg::SP_W-1:0] depth;
  logic [vic_pkg::DATA_W-1:0] spurious;
  wire vec_rd = rd_en && addr == vic_pkg::OFS_CUR_VECTOR;
  wire eoi_wr = wr_en && addr == vic_pkg::OFS_END_OF_INT_CMD;
  // a vector read that finds the line up counts as a take; the unit takes on any qualifying read
  wire push = vec_rd && !normal_interrupt_line_n && depth < 4'h8;
  wire pop = eoi_wr && depth != 4'h0;
  wire spu_wr = wr_en && addr == vic_pkg::OFS_SPURIOUS_VECTOR;
  wire [vic_pkg::SP_W-1:0] next_depth =
    push ? depth + 4'h1 : (pop ? depth - 4'h1 : depth);
  wire [vic_pkg::DATA_W-1:0] next_spurious = spu_wr ? wdata : spurious;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      depth <= '0;
      spurious <= vic_pkg::SPURIOUS_RESET;
    end else begin
      depth <= next_depth;
      spurious <= next_spurious;
    end
  end

  // ************************************************************
  // ***** properties
  // ************************************************************
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  sequence read_at(logic [vic_pkg::ADDR_W-1:0] a);
    rd_en && addr == a;
  endsequence

  chk_read_answered: assert property (rd_en |=> rvalid)
    else $error("no read answer after a read strobe");
  chk_answer_has_cause: assert property (rvalid |-> $past(rd_en))
    else $error("read answer without a read");
  chk_vector_drops_line:
    assert property (vec_rd && !normal_interrupt_line_n
      |=> normal_interrupt_line_n)
    else $error("line still up after vector read");
  chk_idle_vector_zero:
    assert property (read_at(vic_pkg::OFS_CUR_VECTOR) ##0
      (normal_interrupt_line_n && depth == 4'h0)
      |=> rdata == vic_pkg::NO_CURRENT_VECTOR)
    else $error("vector read with nothing current not zero");
  chk_spurious_readback:
    assert property (read_at(vic_pkg::OFS_SPURIOUS_VECTOR)
      |=> rdata == $past(spurious))
    else $error("spurious vector read back wrong");
  chk_unmapped_zero:
    assert property (rd_en && addr[11:9] != 3'h0 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_idle_source_zero:
    assert property (read_at(vic_pkg::OFS_CUR_SOURCE_ID) ##0 depth == 4'h0
      |=> rdata == 32'h0)
    else $error("source number not zero while idle");
  chk_one_access: assert property (!(rd_en && wr_en))
    else $error("read and write in one cycle");
endmodule : vic_link_asserts

// File: sim/test_vectored_irq_command_and_nesting.sv
// self-checking bench: core end and interrupt unit joined by the link
// assumes package and link interface are compiled before this file
module test_vectored_irq_command_and_nesting;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, irq_disable, exit_req, cmd_valid, cmd_write;
  logic [11:0] cmd_addr;
  logic [31:0] cmd_wdata, core_status, return_pc, vec_data, sp;
  logic [31:0] src, src_edge, src_enable, pending;
  logic [95:0] src_prio;
  logic vec_we, cmd_ready, rsp_valid, irq_entry, exit_done;
  logic [4:0] vec_idx, cur_src;
  logic [2:0] cur_level;
  logic [3:0] nest_depth, nest_count;
  logic [3:0] entry_d = 4'h0;
  logic [31:0] rsp_data, handler_addr, saved_status, saved_link, fetch_addr;
  logic [31:0] rsp_q[$], hnd_q[$], vec[32];
  int bad_count = 0;
  int checked = 0;

  vic_link_if link ();
  vic_unit vic_unit_i (.i_core_clk(core_clk), .i_reset(reset), .lnk(link),
    .i_src(src), .i_src_edge(src_edge), .i_src_enable(src_enable),
    .i_src_prio(src_prio), .i_vec_we(vec_we), .i_vec_idx(vec_idx),
    .i_vec_data(vec_data), .o_pending(pending), .o_cur_src(cur_src),
    .o_cur_level(cur_level), .o_nest_depth(nest_depth));
  vic_core_end vic_core_end_i (.i_core_clk(core_clk), .i_reset(reset),
    .lnk(link), .i_irq_disable(irq_disable), .i_core_status(core_status),
    .i_return_pc(return_pc), .i_exit(exit_req), .i_cmd_valid(cmd_valid),
    .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr),
    .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_irq_entry(irq_entry), .o_exit_done(exit_done),
    .o_handler_addr(handler_addr), .o_saved_status(saved_status),
    .o_saved_link(saved_link), .o_fetch_addr(fetch_addr),
    .o_nest_count(nest_count));
  vic_link_asserts vic_link_asserts_i (.i_core_clk(core_clk),
    .i_reset(reset), .addr(link.addr), .wr_en(link.wr_en),
    .rd_en(link.rd_en), .wdata(link.wdata), .rdata(link.rdata),
    .rvalid(link.rvalid),
    .normal_interrupt_line_n(link.normal_interrupt_line_n));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ************************************************************
  // ***** tasks
  // ************************************************************
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (exp !== got) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic step(int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask : step

  task automatic stop_test();
    bad_count += rsp_q.size() + hnd_q.size();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // a fresh edge first, so back to back calls never touch valid twice
  task automatic cmd(logic wr, logic [11:0] a, logic [31:0] d);
    int n = 0;
    step(1);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = d;
    while (!cmd_ready && n < 50) begin
      step(1);
      n++;
    end
    step(1);
    cmd_valid = 1'b0;
    if (n == 50) begin
      bad_count++;
      $display("wrong value cmd ready expected 1 seen 0");
    end
  endtask : cmd

  task automatic rd(logic [11:0] a, logic [31:0] e);
    rsp_q.push_back(e);
    cmd(1'b0, a, 32'h0);
  endtask : rd

  // unmask for one edge only, so a single entry is accepted
  task automatic enter(int idx);
    int n = 0;
    while (link.normal_interrupt_line_n && n < 50) begin
      step(1);
      n++;
    end
    if (n == 50) begin
      bad_count++;
      $display("wrong value line expected 0 seen 1");
    end
    hnd_q.push_back(vec[idx]);
    irq_disable = 1'b0;
    step(1);
    irq_disable = 1'b1;
    step(6);
  endtask : enter

  task automatic leave();
    int n = 0;
    step(1);
    exit_req = 1'b1;
    while (!exit_done && n < 50) begin
      step(1);
      n++;
    end
    exit_req = 1'b0;
    if (n == 50) begin
      bad_count++;
      $display("wrong value exit done expected 1 seen 0");
    end
    step(4);
  endtask : leave

  task automatic expect_state(logic [4:0] s, logic [2:0] l, logic [3:0] d);
    check("source", s, cur_src);
    check("level", l, cur_level);
    check("depth", d, nest_depth);
  endtask : expect_state

  // ************************************************************
  // ***** result monitor
  // ************************************************************
  always @(posedge core_clk) begin
    entry_d <= {entry_d[2:0], irq_entry};
    if (rsp_valid && rsp_q.size() == 0) begin
      bad_count++;
      $display("wrong value read data expected none seen %h", rsp_data);
    end
    if (rsp_valid && rsp_q.size() != 0) begin
      check("read data", rsp_q.pop_front(), rsp_data);
    end
    if (entry_d[2] && hnd_q.size() != 0) begin
      check("handler", hnd_q.pop_front(), handler_addr);
    end
  end

  initial begin
    #20000;
    bad_count++;
    stop_test();
  end

  // ************************************************************
  // ***** tests
  // ************************************************************
  initial begin
    {reset, irq_disable} = 2'h3;
    {exit_req, cmd_valid, cmd_write, vec_we} = 4'h0;
    {cmd_addr, vec_idx, cmd_wdata, core_status} = '0;
    {return_pc, vec_data, src} = '0;
    src_edge = 32'h0000_0220;
    src_enable = 32'h0000_1220;
    src_prio = '0;
    src_prio[17:15] = 3'h2;
    src_prio[29:27] = 3'h5;
    src_prio[38:36] = 3'h3;
    step(4);
    reset = 1'b0;
    void'($urandom(32'hF4473FD2));
    for (int i = 0; i < 32; i++) begin
      vec[i] = $urandom;
      vec_we = 1'b1;
      vec_idx = i[4:0];
      vec_data = vec[i];
      step(1);
    end
    vec_we = 1'b0;
    sp = $urandom;
    rd(vic_pkg::OFS_SPURIOUS_VECTOR, vic_pkg::SPURIOUS_RESET);
    cmd(1'b1, vic_pkg::OFS_SPURIOUS_VECTOR, sp);
    rd(vic_pkg::OFS_SPURIOUS_VECTOR, sp);
    rd(vic_pkg::OFS_CUR_VECTOR, vic_pkg::NO_CURRENT_VECTOR);
    rd(vic_pkg::OFS_CUR_SOURCE_ID, 32'h0);
    rd(12'h200, 32'h0);
    cmd(1'b1, vic_pkg::OFS_INT_SET_CMD, 32'h0060_0028);
    step(3);
    check("pending", 32'h0000_0028, pending);
    cmd(1'b1, vic_pkg::OFS_INT_CLEAR_CMD, 32'h0060_0008);
    step(3);
    check("pending", 32'h0000_0020, pending);
    check("line", 1'b0, link.normal_interrupt_line_n);
    check("entries", 4'h0, nest_count);
    core_status = $urandom;
    return_pc = $urandom;
    enter(5);
    expect_state(5'h05, 3'h2, 4'h1);
    check("line", 1'b1, link.normal_interrupt_line_n);
    check("pending", 1'b0, pending[5]);
    check("link", return_pc - vic_pkg::LINK_ADJUST, saved_link);
    check("fetch", vic_pkg::CORE_IRQ_ENTRY_ADDR, fetch_addr);
    check("status", core_status, saved_status);
    rd(vic_pkg::OFS_CUR_SOURCE_ID, 32'h5);
    cmd(1'b1, vic_pkg::OFS_INT_SET_CMD, 32'h0000_0200);
    step(3);
    check("line", 1'b0, link.normal_interrupt_line_n);
    enter(9);
    expect_state(5'h09, 3'h5, 4'h2);
    src[12] = 1'b1;
    step(6);
    check("line", 1'b1, link.normal_interrupt_line_n);
    leave();
    expect_state(5'h05, 3'h2, 4'h1);
    check("line", 1'b0, link.normal_interrupt_line_n);
    enter(12);
    expect_state(5'h0C, 3'h3, 4'h2);
    src[12] = 1'b0;
    step(3);
    leave();
    check("depth", 4'h1, nest_depth);
    check("line", 1'b1, link.normal_interrupt_line_n);
    cmd(1'b1, vic_pkg::OFS_END_OF_INT_CMD, $urandom);
    step(3);
    expect_state(5'h00, 3'h0, 4'h0);
    cmd(1'b1, vic_pkg::OFS_END_OF_INT_CMD, $urandom);
    step(3);
    check("depth", 4'h0, nest_depth);
    rd(vic_pkg::OFS_CUR_VECTOR, vic_pkg::NO_CURRENT_VECTOR);
    step(10);
    stop_test();
  end
endmodule : test_vectored_irq_command_and_nesting
